/* hdl/rscb_bank.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module rscb_bank #(
  parameter int PORTS = rscb_pkg::PORTS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [rscb_pkg::IDX_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PORTS-1:0] t1_mode,
  input wire logic [PORTS-1:0] line_in_pos,
  input wire logic [PORTS-1:0] line_in_neg,
  input wire logic [PORTS-1:0] line_bit_clk,
  input wire logic [PORTS-1:0] remote_alarm_cond,
  input wire logic [PORTS-1:0] ais_cond,
  input wire logic [PORTS-1:0] frame_loss_cond,
  input wire logic [PORTS-1:0] pulse_density_evt,
  input wire logic [PORTS-1:0] align_change_evt,
  input wire logic [PORTS-1:0] b8zs_evt,
  input wire logic [PORTS-1:0] fbit_stb,
  input wire logic [PORTS-1:0] fbit_err,
  output logic [2*PORTS-1:0] rx_fifo_watermark_sel,
  output logic [6*PORTS-1:0] rx_fifo_watermark_bytes,
  output logic [2*PORTS-1:0] ilv_bus_size,
  output logic [4*PORTS-1:0] ilv_dev_count,
  output logic [PORTS-1:0] ilv_type_sel,
  output logic [PORTS-1:0] ilv_bus_en,
  output logic [4*PORTS-1:0] bus_position,
  output logic [3*PORTS-1:0] spare_code_len,
  output logic [5*PORTS-1:0] spare_len_min,
  output logic [5*PORTS-1:0] spare_len_max,
  output logic [PORTS-1:0] bert_src_dir,
  output logic [PORTS-1:0] bert_unframed_sel,
  output logic [PORTS-1:0] bert_port_en,
  output logic [8*PORTS-1:0] bert_suppress_mask,
  output logic [PORTS-1:0] sig_loss_cond,
  output logic [PORTS-1:0] alarm_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Register index decode

  // True when the bus index hits one register of one port
  function automatic logic reg_hit(input logic [rscb_pkg::IDX_W-1:0] idx,
                                   input int port,
                                   input logic [rscb_pkg::OFF_W-1:0] off);
    logic [rscb_pkg::IDX_W-1:0] want;
    want = {port[rscb_pkg::IDX_W-rscb_pkg::OFF_W-1:0], off};
    return idx == want;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake: one wait cycle, then the answer

  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_fire;
  logic [7:0] rd_port [PORTS];
  logic [PORTS-1:0] rd_hit;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_fire = avs_write & ack_ff & avs_byteenable[0];
  assign avs_readdata = rdata_ff;

  // Next answer: data captured in the wait cycle, unmapped reads give zero
  always_comb begin
    nxt_ack = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read && !ack_ff) begin
      nxt_rdata = 32'h0000_0000;
      for (int p = 0; p < PORTS; p++) begin
        if (rd_hit[p]) begin
          nxt_rdata = {24'h00_0000, rd_port[p]};
        end
      end
    end
  end

  // Handshake registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port register copies and status detectors

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [7:0] wm_ff, ilv_ff, spare_ff, bert_ff, supp_ff, alarm_ff, event_ff;
    logic [7:0] nxt_wm, nxt_ilv, nxt_spare, nxt_bert, nxt_supp;
    logic [7:0] nxt_alarm, nxt_event;
    logic [1:0] pos_sync_ff, neg_sync_ff, clk_sync_ff;
    logic clk_prev_ff;
    logic [7:0] zrun_ff, nxt_zrun;
    logic los_ff, nxt_los;
    logic [3:0] cond_prev_ff;
    logic [3:0] cond_now;
    logic [rscb_pkg::SEF_WINDOW-1:0] fhist_ff, nxt_fhist;
    logic [7:0] alarm_set, event_set;
    logic bit_tick, bit_zero;
    logic [2:0] sef_cnt;
    logic [7:0] wdata;

    assign wdata = avs_writedata[7:0];
    // Line bit strobe is a rising edge of the synchronised line clock
    assign bit_tick = clk_sync_ff[1] & ~clk_prev_ff;
    assign bit_zero = ~pos_sync_ff[1] & ~neg_sync_ff[1];
    // Condition vector ordered remote alarm, AIS, signal loss, frame loss
    assign cond_now = {remote_alarm_cond[p], ais_cond[p], los_ff, frame_loss_cond[p]};

    // Line pins cross into the clock domain through two flip-flops
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        pos_sync_ff <= 2'h0;
        neg_sync_ff <= 2'h0;
        clk_sync_ff <= 2'h0;
        clk_prev_ff <= 1'b0;
      end else begin
        pos_sync_ff <= {pos_sync_ff[0], line_in_pos[p]};
        neg_sync_ff <= {neg_sync_ff[0], line_in_neg[p]};
        clk_sync_ff <= {clk_sync_ff[0], line_bit_clk[p]};
        clk_prev_ff <= clk_sync_ff[1];
      end
    end

    // Zero run counter, loss of signal and framing bit history
    always_comb begin
      nxt_zrun = zrun_ff;
      nxt_los = los_ff;
      nxt_fhist = fhist_ff;
      sef_cnt = 3'h0;
      if (bit_tick) begin
        if (bit_zero) begin
          if (zrun_ff != rscb_pkg::ZERO_RUN_LOS) begin
            nxt_zrun = zrun_ff + 8'h01;
          end
          if (zrun_ff == rscb_pkg::ZERO_RUN_LOS - 8'h01) begin
            nxt_los = 1'b1;
          end
        end else begin
          nxt_zrun = 8'h00;
          nxt_los = 1'b0;
        end
      end
      if (fbit_stb[p]) begin
        nxt_fhist = {fhist_ff[rscb_pkg::SEF_WINDOW-2:0], fbit_err[p]};
      end
      for (int i = 0; i < rscb_pkg::SEF_WINDOW; i++) begin
        sef_cnt = sef_cnt + {2'h0, nxt_fhist[i]};
      end
    end

    // Flag set terms
    always_comb begin
      alarm_set = 8'h00;
      // Clear flags on falling edges, detect flags on rising edges
      alarm_set[rscb_pkg::ALARM_CLR_LSB +: 4] = cond_prev_ff & ~cond_now;
      alarm_set[rscb_pkg::ALARM_DET_LSB +: 4] = cond_now & ~cond_prev_ff;
      event_set = 8'h00;
      event_set[rscb_pkg::EVT_PDV_BIT] = pulse_density_evt[p];
      event_set[rscb_pkg::EVT_ALIGN_BIT] = align_change_evt[p];
      event_set[rscb_pkg::EVT_Z8_BIT] = bit_tick & bit_zero
                                        & (zrun_ff == rscb_pkg::ZERO_RUN_8 - 8'h01);
      event_set[rscb_pkg::EVT_Z16_BIT] = bit_tick & bit_zero
                                         & (zrun_ff == rscb_pkg::ZERO_RUN_16 - 8'h01);
      event_set[rscb_pkg::EVT_SEF_BIT] = fbit_stb[p] & (sef_cnt >= rscb_pkg::SEF_ERRS);
      event_set[rscb_pkg::EVT_B8ZS_BIT] = b8zs_evt[p];
      event_set[rscb_pkg::EVT_FBE_BIT] = fbit_stb[p] & fbit_err[p];
      event_set = event_set & {8{t1_mode[p]}};
    end

    // Register writes; on a flag a new event wins over a clear
    always_comb begin
      nxt_wm = wm_ff;
      nxt_ilv = ilv_ff;
      nxt_spare = spare_ff;
      nxt_bert = bert_ff;
      nxt_supp = supp_ff;
      nxt_alarm = alarm_ff;
      nxt_event = event_ff;
      if (wr_fire) begin
        if (reg_hit(avs_address, p, rscb_pkg::OFF_WATERMARK)) begin
          nxt_wm = wdata & rscb_pkg::MASK_WATERMARK;
        end else if (reg_hit(avs_address, p, rscb_pkg::OFF_ILV_CTRL)) begin
          nxt_ilv = wdata & rscb_pkg::MASK_ILV_CTRL;
        end else if (reg_hit(avs_address, p, rscb_pkg::OFF_SPARE_CTRL)) begin
          nxt_spare = wdata & rscb_pkg::MASK_SPARE_CTRL;
        end else if (reg_hit(avs_address, p, rscb_pkg::OFF_BERT_CTRL)) begin
          nxt_bert = wdata & rscb_pkg::MASK_BERT_CTRL;
        end else if (reg_hit(avs_address, p, rscb_pkg::OFF_BERT_SUPP)) begin
          nxt_supp = wdata;
        end else if (reg_hit(avs_address, p, rscb_pkg::OFF_ALARM_LS)) begin
          nxt_alarm = alarm_ff & ~wdata;
        end else if (reg_hit(avs_address, p, rscb_pkg::OFF_EVENT_LS)) begin
          nxt_event = event_ff & ~wdata;
        end
      end
      nxt_alarm = nxt_alarm | alarm_set;
      nxt_event = (nxt_event | event_set) & rscb_pkg::MASK_EVENT_LS;
    end

    // Register and detector state
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        wm_ff <= rscb_pkg::REG_RESET;
        ilv_ff <= rscb_pkg::REG_RESET;
        spare_ff <= rscb_pkg::REG_RESET;
        bert_ff <= rscb_pkg::REG_RESET;
        supp_ff <= rscb_pkg::REG_RESET;
        alarm_ff <= rscb_pkg::REG_RESET;
        event_ff <= rscb_pkg::REG_RESET;
        zrun_ff <= 8'h00;
        los_ff <= 1'b0;
        cond_prev_ff <= 4'h0;
        fhist_ff <= '0;
      end else begin
        wm_ff <= nxt_wm;
        ilv_ff <= nxt_ilv;
        spare_ff <= nxt_spare;
        bert_ff <= nxt_bert;
        supp_ff <= nxt_supp;
        alarm_ff <= nxt_alarm;
        event_ff <= nxt_event;
        zrun_ff <= nxt_zrun;
        los_ff <= nxt_los;
        cond_prev_ff <= cond_now;
        fhist_ff <= nxt_fhist;
      end
    end

    // Read view of this port
    always_comb begin
      rd_hit[p] = 1'b1;
      rd_port[p] = 8'h00;
      if (reg_hit(avs_address, p, rscb_pkg::OFF_WATERMARK)) begin
        rd_port[p] = wm_ff;
      end else if (reg_hit(avs_address, p, rscb_pkg::OFF_ILV_CTRL)) begin
        rd_port[p] = ilv_ff;
      end else if (reg_hit(avs_address, p, rscb_pkg::OFF_SPARE_CTRL)) begin
        rd_port[p] = spare_ff;
      end else if (reg_hit(avs_address, p, rscb_pkg::OFF_BERT_CTRL)) begin
        rd_port[p] = bert_ff;
      end else if (reg_hit(avs_address, p, rscb_pkg::OFF_BERT_SUPP)) begin
        rd_port[p] = supp_ff;
      end else if (reg_hit(avs_address, p, rscb_pkg::OFF_ALARM_LS)) begin
        rd_port[p] = alarm_ff;
      end else if (reg_hit(avs_address, p, rscb_pkg::OFF_EVENT_LS)) begin
        rd_port[p] = event_ff;
      end else begin
        rd_hit[p] = 1'b0;
      end
    end

    // Watermark depth lookup
    always_comb begin
      case (wm_ff[1:0])
        2'h0: rx_fifo_watermark_bytes[6*p +: 6] = rscb_pkg::WM_BYTES_0;
        2'h1: rx_fifo_watermark_bytes[6*p +: 6] = rscb_pkg::WM_BYTES_1;
        2'h2: rx_fifo_watermark_bytes[6*p +: 6] = rscb_pkg::WM_BYTES_2;
        default: rx_fifo_watermark_bytes[6*p +: 6] = rscb_pkg::WM_BYTES_3;
      endcase
    end

    // Interleave bus device count; the reserved size yields zero
    always_comb begin
      case (ilv_ff[rscb_pkg::ILV_SIZE_LSB +: 2])
        2'h0: ilv_dev_count[4*p +: 4] = 4'h2;
        2'h1: ilv_dev_count[4*p +: 4] = 4'h4;
        2'h2: ilv_dev_count[4*p +: 4] = 4'h8;
        default: ilv_dev_count[4*p +: 4] = 4'h0;
      endcase
    end

    // Spare code length range, T1 only
    always_comb begin
      spare_len_min[5*p +: 5] = 5'h00;
      spare_len_max[5*p +: 5] = 5'h00;
      if (t1_mode[p]) begin
        if (spare_ff[2:0] == 3'h7) begin
          spare_len_min[5*p +: 5] = rscb_pkg::SPARE_LONG_MIN;
          spare_len_max[5*p +: 5] = rscb_pkg::SPARE_LONG_MAX;
        end else begin
          spare_len_min[5*p +: 5] = {2'h0, spare_ff[2:0]} + 5'h01;
          spare_len_max[5*p +: 5] = {2'h0, spare_ff[2:0]} + 5'h01;
        end
      end
    end

    // Control outputs taken from the registers
    assign rx_fifo_watermark_sel[2*p +: 2] = wm_ff[1:0];
    assign ilv_bus_size[2*p +: 2] = ilv_ff[rscb_pkg::ILV_SIZE_LSB +: 2];
    assign ilv_type_sel[p] = ilv_ff[rscb_pkg::ILV_TYPE_BIT];
    assign ilv_bus_en[p] = ilv_ff[rscb_pkg::ILV_EN_BIT]
                           & (ilv_ff[rscb_pkg::ILV_SIZE_LSB +: 2] != rscb_pkg::ILV_SIZE_RSVD);
    assign bus_position[4*p +: 4] = {1'b0, ilv_ff[rscb_pkg::ILV_POS_LSB +: 3]} + 4'h1;
    assign spare_code_len[3*p +: 3] = spare_ff[2:0];
    assign bert_src_dir[p] = bert_ff[rscb_pkg::BERT_DIR_BIT];
    assign bert_unframed_sel[p] = bert_ff[rscb_pkg::BERT_UNFR_BIT] & t1_mode[p];
    assign bert_port_en[p] = bert_ff[rscb_pkg::BERT_EN_BIT];
    assign bert_suppress_mask[8*p +: 8] = supp_ff;
    assign sig_loss_cond[p] = los_ff;
    assign alarm_pending[p] = |alarm_ff;
  end

endmodule

/* hdl/rscb_pkg.sv */
package rscb_pkg;
  // Bank geometry
  localparam int PORTS = 8;
  localparam int IDX_W = 12;
  localparam int OFF_W = 9;
  // Register indexes inside one port window (word address = index)
  localparam logic [OFF_W-1:0] OFF_WATERMARK = 9'h087;
  localparam logic [OFF_W-1:0] OFF_ILV_CTRL = 9'h088;
  localparam logic [OFF_W-1:0] OFF_SPARE_CTRL = 9'h089;
  localparam logic [OFF_W-1:0] OFF_BERT_CTRL = 9'h08A;
  localparam logic [OFF_W-1:0] OFF_BERT_SUPP = 9'h08B;
  localparam logic [OFF_W-1:0] OFF_ALARM_LS = 9'h090;
  localparam logic [OFF_W-1:0] OFF_EVENT_LS = 9'h091;
  // Reset value shared by every register of the bank
  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable bit masks; masked bits read as zero
  localparam logic [7:0] MASK_WATERMARK = 8'h03;
  localparam logic [7:0] MASK_ILV_CTRL = 8'h7F;
  localparam logic [7:0] MASK_SPARE_CTRL = 8'h07;
  localparam logic [7:0] MASK_BERT_CTRL = 8'h07;
  localparam logic [7:0] MASK_EVENT_LS = 8'hBF;
  // Interleave control fields
  localparam int ILV_SIZE_LSB = 5;
  localparam int ILV_TYPE_BIT = 4;
  localparam int ILV_EN_BIT = 3;
  localparam int ILV_POS_LSB = 0;
  localparam logic [1:0] ILV_SIZE_RSVD = 2'h3;
  // BERT control fields
  localparam int BERT_DIR_BIT = 2;
  localparam int BERT_UNFR_BIT = 1;
  localparam int BERT_EN_BIT = 0;
  // Alarm latched status: clear flags high nibble, detect flags low nibble
  localparam int ALARM_CLR_LSB = 4;
  localparam int ALARM_DET_LSB = 0;
  // Event latched status bits
  localparam int EVT_PDV_BIT = 7;
  localparam int EVT_ALIGN_BIT = 5;
  localparam int EVT_Z8_BIT = 4;
  localparam int EVT_Z16_BIT = 3;
  localparam int EVT_SEF_BIT = 2;
  localparam int EVT_B8ZS_BIT = 1;
  localparam int EVT_FBE_BIT = 0;
  // Watermark depths in bytes
  localparam logic [5:0] WM_BYTES_0 = 6'h04;
  localparam logic [5:0] WM_BYTES_1 = 6'h10;
  localparam logic [5:0] WM_BYTES_2 = 6'h20;
  localparam logic [5:0] WM_BYTES_3 = 6'h30;
  // Zero run thresholds and framing error window
  localparam logic [7:0] ZERO_RUN_8 = 8'h08;
  localparam logic [7:0] ZERO_RUN_16 = 8'h10;
  localparam logic [7:0] ZERO_RUN_LOS = 8'hC0;
  localparam int SEF_WINDOW = 6;
  localparam logic [2:0] SEF_ERRS = 3'h2;
  // Spare code lengths
  localparam logic [4:0] SPARE_LONG_MIN = 5'h08;
  localparam logic [4:0] SPARE_LONG_MAX = 5'h10;
endpackage

/* tb/rscb_bank_asserts.sv */
`timescale 1ns/1ps
module rscb_bank_asserts #(
  parameter int PORTS = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [2*PORTS-1:0] rx_fifo_watermark_sel,
  input wire logic [6*PORTS-1:0] rx_fifo_watermark_bytes,
  input wire logic [2*PORTS-1:0] ilv_bus_size,
  input wire logic [4*PORTS-1:0] ilv_dev_count,
  input wire logic [PORTS-1:0] ilv_bus_en,
  input wire logic [PORTS-1:0] t1_mode,
  input wire logic [3*PORTS-1:0] spare_code_len,
  input wire logic [5*PORTS-1:0] spare_len_min,
  input wire logic [5*PORTS-1:0] spare_len_max,
  input wire logic [PORTS-1:0] bert_unframed_sel,
  input wire logic [PORTS-1:0] ais_cond,
  input wire logic [PORTS-1:0] sig_loss_cond,
  input wire logic [PORTS-1:0] alarm_pending
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Watermark depth for a select code
  function automatic logic [5:0] wm_of(input logic [1:0] s);
    return s[1] ? (s[0] ? 6'h30 : 6'h20) : (s[0] ? 6'h10 : 6'h04);
  endfunction
  // Each request waits exactly one cycle
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  ////////////////////////////////////////////////////////////////////////////////
  // Per port decodes and flag timing
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    a_wm_decode: assert property (
      rx_fifo_watermark_bytes[6*p +: 6] == wm_of(rx_fifo_watermark_sel[2*p +: 2]))
      else $error("watermark depth wrong");
    a_dev_count: assert property (ilv_dev_count[4*p +: 4] ==
      (ilv_bus_size[2*p +: 2] == 2'h3 ? 4'h0 : 4'h2 << ilv_bus_size[2*p +: 2]))
      else $error("device count wrong");
    a_bus_en_rsvd: assert property (ilv_bus_en[p] |-> ilv_bus_size[2*p +: 2] != 2'h3)
      else $error("bus enabled with reserved size");
    a_spare_len: assert property (t1_mode[p] && $past(t1_mode[p]) |->
      spare_len_max[5*p +: 5] == (spare_code_len[3*p +: 3] == 3'h7 ? 5'h10 :
      5'(spare_code_len[3*p +: 3]) + 5'h01) && spare_len_min[5*p +: 5] ==
      (spare_code_len[3*p +: 3] == 3'h7 ? 5'h08 : 5'(spare_code_len[3*p +: 3]) + 5'h01))
      else $error("spare length wrong");
    a_unframed_t1: assert property (bert_unframed_sel[p] |-> t1_mode[p] || $past(t1_mode[p]))
      else $error("unframed select outside T1");
    a_ais_detect: assert property ($rose(ais_cond[p]) |=> alarm_pending[p])
      else $error("ais rise not latched");
    a_los_detect: assert property ($rose(sig_loss_cond[p]) |-> ##[1:2] alarm_pending[p])
      else $error("signal loss not latched");
    a_pending_hold: assert property (alarm_pending[p] && !avs_write |=> alarm_pending[p])
      else $error("alarm flag lost without write");
  end
endmodule
bind rscb_bank rscb_bank_asserts #(.PORTS(PORTS)) u_chk (.sys_clk, .resetn, .avs_read,
  .avs_write, .avs_waitrequest, .rx_fifo_watermark_sel, .rx_fifo_watermark_bytes, .ilv_bus_size,
  .ilv_dev_count, .ilv_bus_en, .t1_mode, .spare_code_len, .spare_len_min, .spare_len_max,
  .bert_unframed_sel, .ais_cond, .sig_loss_cond, .alarm_pending);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int NP = rscb_pkg::PORTS;
  localparam logic [8:0] OFFS [5] = '{rscb_pkg::OFF_WATERMARK, rscb_pkg::OFF_ILV_CTRL,
    rscb_pkg::OFF_SPARE_CTRL, rscb_pkg::OFF_BERT_CTRL, rscb_pkg::OFF_BERT_SUPP};
  localparam logic [7:0] MSKS [5] = '{8'h03, 8'h7F, 8'h07, 8'h07, 8'hFF};
  localparam logic [5:0] WMB [4] = '{6'h04, 6'h10, 6'h20, 6'h30};
  localparam int ALM [3] = '{3, 2, 0};
  localparam logic [8:0] ALS = rscb_pkg::OFF_ALARM_LS;
  localparam logic [8:0] EVS = rscb_pkg::OFF_EVENT_LS;
  logic sys_clk = 1'b0;
  logic resetn, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [NP-1:0] t1_mode, line_in_pos, line_in_neg, line_bit_clk, remote_alarm_cond, ais_cond;
  logic [NP-1:0] frame_loss_cond, pulse_density_evt, align_change_evt, b8zs_evt, fbit_stb;
  logic [NP-1:0] fbit_err, ilv_type_sel, ilv_bus_en, bert_src_dir, bert_unframed_sel;
  logic [NP-1:0] bert_port_en, sig_loss_cond, alarm_pending;
  logic [2*NP-1:0] rx_fifo_watermark_sel, ilv_bus_size;
  logic [6*NP-1:0] rx_fifo_watermark_bytes;
  logic [4*NP-1:0] ilv_dev_count, bus_position;
  logic [3*NP-1:0] spare_code_len;
  logic [5*NP-1:0] spare_len_min, spare_len_max;
  logic [8*NP-1:0] bert_suppress_mask;
  logic [7:0] exp_q [$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int p;
  // Clock
  always #12.5 sys_clk = ~sys_clk;
  rscb_bank #(.PORTS(NP)) dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .t1_mode, .line_in_pos,
    .line_in_neg, .line_bit_clk, .remote_alarm_cond, .ais_cond, .frame_loss_cond,
    .pulse_density_evt, .align_change_evt, .b8zs_evt, .fbit_stb, .fbit_err,
    .rx_fifo_watermark_sel, .rx_fifo_watermark_bytes, .ilv_bus_size, .ilv_dev_count,
    .ilv_type_sel, .ilv_bus_en, .bus_position, .spare_code_len, .spare_len_min, .spare_len_max,
    .bert_src_dir, .bert_unframed_sel, .bert_port_en, .bert_suppress_mask, .sig_loss_cond,
    .alarm_pending);
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask
  // One Avalon access to port p, held until a rising edge sees waitrequest low
  task automatic bus(input logic r, input logic [8:0] off, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge sys_clk);
    avs_read <= r;
    avs_write <= !r;
    avs_address <= {3'(p), off};
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    // Released only after the accepting edge; the watchdog ends a hang
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] off, input logic [7:0] d);
    bus(1'b0, off, d, 4'h1);
  endtask
  task automatic rd(input logic [8:0] off, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b1, off, 8'h00, 4'hF);
  endtask
  // Read data taken at the accepting rising edge, against the oldest note
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check("readdata", avs_readdata, {24'h000000, exp_q.pop_front()});
    end
  end
  // Alarm condition level on port p
  task automatic cond(input int i, input logic v);
    @(posedge sys_clk);
    if (i == 3) remote_alarm_cond[p] <= v;
    else if (i == 2) ais_cond[p] <= v;
    else frame_loss_cond[p] <= v;
    settle();
  endtask
  // Line bits on port p, slow bit clock
  task automatic bits(input logic v, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      line_in_pos[p] <= v;
      repeat (4) @(posedge sys_clk);
      line_bit_clk[p] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      line_bit_clk[p] <= 1'b0;
    end
    settle();
  endtask
  // Every framer event, framing error twice within six strobes
  task automatic evts;
    @(posedge sys_clk);
    {pulse_density_evt[p], align_change_evt[p], b8zs_evt[p], fbit_stb[p], fbit_err[p]} <= 5'h1F;
    @(posedge sys_clk);
    {pulse_density_evt[p], align_change_evt[p], b8zs_evt[p], fbit_stb[p], fbit_err[p]} <= 5'h00;
    @(posedge sys_clk);
    {fbit_stb[p], fbit_err[p]} <= 2'h3;
    @(posedge sys_clk);
    {fbit_stb[p], fbit_err[p]} <= 2'h0;
    settle();
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int c;
    logic [7:0] d;
    {resetn, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {line_in_neg, line_bit_clk, remote_alarm_cond, ais_cond, frame_loss_cond} = '0;
    {pulse_density_evt, align_change_evt, b8zs_evt, fbit_stb, fbit_err} = '0;
    line_in_pos = '1;
    t1_mode = '1;
    p = NP - 1;
    d = 8'($urandom(32'h37f1));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    settle();
    check("wm_bytes", 32'(rx_fifo_watermark_bytes[6*p +: 6]), 32'h4);
    check("dev_count", 32'(ilv_dev_count[4*p +: 4]), 32'h2);
    for (c = 0; c < 5; c++) rd(OFFS[c], 8'h00);
    rd(ALS, 8'h00);
    rd(EVS, 8'h00);
    for (c = 0; c < 5; c++) begin
      p = $urandom_range(NP - 1);
      d = 8'($urandom);
      wr(OFFS[c], d);
      rd(OFFS[c], d & MSKS[c]);
      p = (p + 1) % NP;
      rd(OFFS[c], 8'h00);
    end
    wr(9'h0A0, 8'hFF);
    rd(9'h0A0, 8'h00);
    p = $urandom_range(NP - 1);
    for (c = 0; c < 4; c++) begin
      wr(OFFS[0], 8'(c));
      settle();
      check("wm_bytes", 32'(rx_fifo_watermark_bytes[6*p +: 6]), 32'(WMB[c]));
      check("wm_sel", 32'(rx_fifo_watermark_sel[2*p +: 2]), 32'(c));
    end
    for (c = 0; c < 8; c++) begin
      wr(OFFS[1], {1'b0, 2'(c), 1'(c), 1'(c != 5), 3'(c)});
      settle();
      check("dev_count", 32'(ilv_dev_count[4*p +: 4]), c % 4 == 3 ? 32'h0 : 32'h2 << (c % 4));
      check("bus_size", 32'(ilv_bus_size[2*p +: 2]), 32'(c % 4));
      check("ilv_type", 32'(ilv_type_sel[p]), 32'(c % 2));
      check("bus_en", 32'(ilv_bus_en[p]), 32'(c != 5 && c % 4 != 3));
      check("position", 32'(bus_position[4*p +: 4]), 32'(c + 1));
    end
    for (c = 0; c < 8; c++) begin
      wr(OFFS[3], 8'(c));
      wr(OFFS[2], 8'(c));
      settle();
      check("bert_dir", 32'(bert_src_dir[p]), 32'(c / 4));
      check("bert_unfr", 32'(bert_unframed_sel[p]), 32'((c / 2) % 2));
      check("bert_en", 32'(bert_port_en[p]), 32'(c % 2));
      check("spare_code", 32'(spare_code_len[3*p +: 3]), 32'(c));
      check("spare_min", 32'(spare_len_min[5*p +: 5]), c < 7 ? 32'(c + 1) : 32'h8);
      check("spare_max", 32'(spare_len_max[5*p +: 5]), c < 7 ? 32'(c + 1) : 32'h10);
    end
    d = 8'($urandom);
    wr(OFFS[4], d);
    bus(1'b0, OFFS[4], ~d, 4'h0);
    settle();
    check("suppress", 32'(bert_suppress_mask[8*p +: 8]), 32'(d));
    for (c = 0; c < 3; c++) begin
      cond(ALM[c], 1'b1);
      check("pending", 32'(alarm_pending[p]), 32'h1);
      rd(ALS, 8'h01 << ALM[c]);
      cond(ALM[c], 1'b0);
      rd(ALS, 8'h11 << ALM[c]);
      wr(ALS, 8'h11 << ALM[c]);
      rd(ALS, 8'h00);
      settle();
      check("pending", 32'(alarm_pending[p]), 32'h0);
    end
    evts();
    rd(EVS, 8'hA7);
    check("pending", 32'(alarm_pending[p]), 32'h0);
    wr(EVS, 8'hFF);
    @(posedge sys_clk);
    t1_mode[p] <= 1'b0;
    settle();
    check("spare_max", 32'(spare_len_max[5*p +: 5]), 32'h0);
    check("bert_unfr", 32'(bert_unframed_sel[p]), 32'h0);
    evts();
    rd(EVS, 8'h00);
    @(posedge sys_clk);
    t1_mode[p] <= 1'b1;
    bits(1'b1, 1);
    bits(1'b0, 7);
    rd(EVS, 8'h00);
    bits(1'b0, 1);
    rd(EVS, 8'h10);
    wr(EVS, 8'h10);
    bits(1'b0, 8);
    rd(EVS, 8'h08);
    bits(1'b0, 175);
    check("sig_loss", 32'(sig_loss_cond[p]), 32'h0);
    bits(1'b0, 1);
    check("sig_loss", 32'(sig_loss_cond[p]), 32'h1);
    bits(1'b1, 1);
    rd(ALS, 8'h22);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(ALS, 8'h00);
    rd(OFFS[4], 8'h00);
    repeat (4) @(posedge sys_clk);
    final_report();
  end
endmodule
